// *** bench/band_norm_quantize_code_test.sv ***
// Self-checking bench for the band norm quantizer and coder.
`timescale 1ns/1ps
module band_norm_quantize_code_test
   import norm_code_pkg::*;
;
   logic CLK_I = 1'b0;
   logic RST_I = 1'b1;
   logic COEF_VALID_I = 1'b0;
   logic signed [15:0] COEF_I = 16'sh0000;
   logic COEF_BAND_LAST_I = 1'b0;
   logic FULLBAND_I = 1'b0;
   logic [IDX_W-1:0] NORM_ADDR_I = 6'h00;
   logic slow = 1'b0;
   logic [1:0] cheap = 2'h0;
   logic COEF_READY_O, FIELD_VALID_O, FIELD_READY_I, FIELD_LAST_O, NORM_VALID_O;
   logic [SYM_W-1:0] LUT_SYM_O, LUT_CTX_O;
   logic [CODE_W-1:0] CTX_CODE_I, RSZ_CODE_I, FIELD_CODE_O;
   logic [LEN_W-1:0] CTX_LEN_I, RSZ_LEN_I, FIELD_LEN_O;
   logic [IDX_W-1:0] NORM_IDX_O;
   logic [FIELD_W-1:0] got [$];
   int n_mismatch = 0;
   int tests_run = 0;
   localparam logic [6:0] HCODE [32] = '{7'h1a, 7'h3a, 7'h5a, 7'h7a, 7'h1b, 7'h3b, 7'h5b,
      7'h7b, 7'h0c, 7'h1c, 7'h2c, 7'h3c, 7'h02, 7'h06, 7'h04, 7'h06, 7'h00, 7'h02, 7'h0a,
      7'h0e, 7'h0e, 7'h1e, 7'h2e, 7'h3e, 7'h1e, 7'h3e, 7'h5e, 7'h7e, 7'h1f, 7'h3f, 7'h5f, 7'h7f};

   always #25 CLK_I = ~CLK_I;

   band_norm_quantize_code u_dut (.CLK_I(CLK_I), .RST_I(RST_I), .COEF_VALID_I(COEF_VALID_I),
      .COEF_READY_O(COEF_READY_O), .COEF_I(COEF_I), .COEF_BAND_LAST_I(COEF_BAND_LAST_I),
      .FULLBAND_I(FULLBAND_I), .LUT_SYM_O(LUT_SYM_O), .LUT_CTX_O(LUT_CTX_O),
      .CTX_CODE_I(CTX_CODE_I), .CTX_LEN_I(CTX_LEN_I), .RSZ_CODE_I(RSZ_CODE_I),
      .RSZ_LEN_I(RSZ_LEN_I), .FIELD_VALID_O(FIELD_VALID_O), .FIELD_READY_I(FIELD_READY_I),
      .FIELD_CODE_O(FIELD_CODE_O), .FIELD_LEN_O(FIELD_LEN_O), .FIELD_LAST_O(FIELD_LAST_O),
      .NORM_ADDR_I(NORM_ADDR_I), .NORM_IDX_O(NORM_IDX_O), .NORM_VALID_O(NORM_VALID_O));

   norm_stage_model u_model (.clk_i(CLK_I), .rst_i(RST_I), .field_ready_o(FIELD_READY_I),
      .slow_i(slow), .cheap_i(cheap), .sym_i(LUT_SYM_O), .ctx_i(LUT_CTX_O),
      .ctx_code_o(CTX_CODE_I), .ctx_len_o(CTX_LEN_I), .rsz_code_o(RSZ_CODE_I),
      .rsz_len_o(RSZ_LEN_I));

   always @(posedge CLK_I) begin
      if (FIELD_VALID_O === 1'b1 && FIELD_READY_I === 1'b1) begin
         got.push_back({FIELD_CODE_O, FIELD_LEN_O, FIELD_LAST_O});
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic int hlen(input int s);
      if (s < 8 || s > 23) return 7;
      if (s < 12 || s > 19) return 6;
      if (s == 12 || s == 13 || s == 18 || s == 19) return 4;
      return 3;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Bands hold one, two or four equal powers of two, so the mean square is exact.
   task automatic run_frame(input logic fb, input int pat, input logic [1:0] sel,
                            input logic slw);
      int n, b, l, w;
      int ex [44];
      int idx [44];
      int sym [44];
      int cost [4];
      logic [1:0] m;
      logic [4:0] s;
      logic [4:0] ctx;
      logic [15:0] c;
      logic [4:0] ln;
      n = fb ? NBANDS_FB : NBANDS_WB;
      for (b = 0; b < n; b++) begin
         ex[b] = (pat == 0) ? ((b % 2) ? 7 : 14) : (pat == 1) ? (b ? 10 : -1) : (b ? -1 : 14);
         idx[b] = (ex[b] < 0) ? (b ? 39 : 31) : 34 - 2 * ex[b];
      end
      for (b = n - 2; b >= 0; b--) begin
         if (idx[b + 1] - idx[b] < -15) begin
            idx[b] = idx[b + 1];
         end
      end
      for (b = 0; b < n - 1; b++) begin
         if (idx[b + 1] - idx[b] > 16) begin
            idx[b + 1] = idx[b] + 16;
         end
      end
      cost = '{0, 0, 0, 0};
      for (b = 0; b < n - 1; b++) begin
         sym[b] = idx[b + 1] - idx[b] + 15;
         cost[0] += (sel == 2'h1) ? 1 : 10;
         cost[1] += (sel == 2'h2) ? 1 : 10;
         cost[2] += hlen(sym[b]);
         cost[3] += 5;
      end
      m = 2'h0;
      for (b = 1; b < 4; b++) begin
         if (cost[b] < cost[m]) begin
            m = b[1:0];
         end
      end
      got.delete();
      @(posedge CLK_I);
      FULLBAND_I <= fb;
      cheap <= sel;
      slow <= slw;
      for (b = 0; b < n; b++) begin
         l = 1 << (b % 3);
         for (int i = 0; i < l; i++) begin
            COEF_VALID_I <= 1'b1;
            COEF_I <= (ex[b] < 0) ? 16'sh0000 : 16'(1 << ex[b]);
            COEF_BAND_LAST_I <= (i == l - 1);
            @(negedge CLK_I);
            while (COEF_READY_O !== 1'b1) @(negedge CLK_I);
            @(posedge CLK_I);
         end
      end
      COEF_VALID_I <= 1'b0;
      w = 0;
      while (got.size() < n + 1 && w < 3000) begin
         @(posedge CLK_I);
         w++;
      end
      check(got.size(), n + 1, "field count");
      // The context bias is left at its default of zero.
      ctx = 5'(idx[0]);
      for (b = 0; b <= n && b < got.size(); b++) begin
         if (b < 2) begin
            c = b ? 16'(idx[0]) : {14'h0000, m};
            ln = b ? FIXED_LEN : SEL_LEN;
         end else begin
            s = 5'(sym[b - 2]);
            case (m)
               2'h0: c = {15'h0000, s[0] ^ ctx[0]};
               2'h1: c = {15'h0000, ~s[0]};
               2'h2: c = {9'h000, HCODE[s]};
               default: c = {11'h000, s};
            endcase
            ln = (m == 2'h2) ? 5'(hlen(s)) : (m == 2'h3) ? FIXED_LEN : 5'h01;
            ctx = s;
         end
         check(got[b], {c, ln, b == n}, "field");
      end
      for (b = 0; b < n; b++) begin
         NORM_ADDR_I <= 6'(b);
         @(posedge CLK_I);
         @(negedge CLK_I);
         check(NORM_VALID_O, 1'b1, "norms ready");
         check(NORM_IDX_O, idx[b], "norm index");
         @(posedge CLK_I);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      RST_I <= 1'b1;
      repeat (7) @(posedge CLK_I);
      @(negedge CLK_I);
      check(COEF_READY_O, 1'b1, "ready in reset");
      check(FIELD_VALID_O, 1'b0, "no field in reset");
      check(NORM_VALID_O, 1'b0, "no norms in reset");
      @(posedge CLK_I);
      RST_I <= 1'b0;
   endtask

   // Alternating levels give seven-bit Huffman codes, so direct packing must win.
   task automatic t_pack_mode();
      run_frame(1'b0, 0, 2'h0, 1'b0);
   endtask

   // A silent lowest band saturates, then is lifted by the downward pass.
   task automatic t_normal_saturate();
      run_frame(1'b0, 1, 2'h0, 1'b0);
   endtask

   // Full band with a slow writer fills the output buffer; upward clamping twice.
   task automatic t_ctx_fullband();
      run_frame(1'b1, 2, 2'h1, 1'b1);
   endtask

   task automatic t_rsz_mode();
      run_frame(1'b0, 2, 2'h2, 1'b0);
   endtask

   initial begin
      t_reset_values();
      t_pack_mode();
      t_normal_saturate();
      t_ctx_fullband();
      t_rsz_mode();
      end_of_test();
   end

   initial begin
      #2000000;
      n_mismatch++;
      end_of_test();
   end
endmodule

// *** bench/norm_stage_model.sv ***
// Model of the bitstream writer and of the external context and resized code tables.
`timescale 1ns/1ps
module norm_stage_model
   import norm_code_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Writer side
   output logic field_ready_o,
   input wire logic slow_i,
   // Table side
   input wire logic [1:0] cheap_i,
   input wire logic [SYM_W-1:0] sym_i,
   input wire logic [SYM_W-1:0] ctx_i,
   output logic [CODE_W-1:0] ctx_code_o,
   output logic [LEN_W-1:0] ctx_len_o,
   output logic [CODE_W-1:0] rsz_code_o,
   output logic [LEN_W-1:0] rsz_len_o
);
   logic [3:0] tick;

   ////////////////////////////////////////////////////////////////////////////////
   // The writer stalls often, and for long stretches when slow, so fields must wait.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick <= 4'h0;
      end else begin
         tick <= tick + 4'h1;
      end
   end
   assign field_ready_o = slow_i ? (tick == 4'hf) : (tick[1:0] != 2'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // A cheap table gives one-bit codes; the context one mixes in the context so it matters.
   assign ctx_len_o = (cheap_i == 2'h1) ? 5'h01 : 5'h0a;
   assign ctx_code_o = (cheap_i == 2'h1) ? {15'h0000, sym_i[0] ^ ctx_i[0]} : {11'h000, sym_i};
   assign rsz_len_o = (cheap_i == 2'h2) ? 5'h01 : 5'h0a;
   assign rsz_code_o = (cheap_i == 2'h2) ? {15'h0000, ~sym_i[0]} : {11'h000, sym_i};
endmodule

// *** rtl/band_norm_quantize_code.sv ***
// Per-band norm computation, log quantization, differential constraint and norm coding.
//
// Function
// RQ1 - Norm is RMS of band coefficients; band length is last minus first bin plus one.
// RQ2 - Norms quantized on forty log levels three decibels apart.
// RQ3 - Norm index is thirty-four minus twice log2 of the norm.
// RQ4 - Lowest band index saturates to 0..31, others to 0..39.
// RQ5 - Lowest band index is sent unmodified in five bits.
// RQ6 - Differential index is upper band index minus lower band index.
// RQ7 - Downward pass: lower index takes upper index when difference below minus fifteen.
// RQ8 - Upward pass: difference above sixteen clamps, upper index becomes lower plus sixteen.
// RQ9 - Fifteen is added to each difference, giving symbols 0..31.
// RQ10 - All four schemes are costed and the cheapest is chosen.
// RQ11 - Two-bit scheme code: 0 context, 1 resized, 2 normal Huffman, 3 packing.
// RQ12 - Context of first symbol is lowest index minus bias, then the previous symbol.
// RQ13 - Packing mode writes each symbol as a plain five-bit field.
// RQ14 - Normal Huffman uses the fixed table, 16 as 000 and 0 as 0011010.
// RQ15 - Resized Huffman codes symbols with the low-rate coder's resized table.
// RQ16 - Twenty-six bands for wideband, forty-four for fullband.
// RQ17 - Field order: scheme, lowest band index, then differential codes low to high.
// RQ18 - Reconstructed indices after the passes are kept for bit allocation.
`timescale 1ns/1ps
module band_norm_quantize_code
   import norm_code_pkg::*;
#(
   parameter int COEF_W = 16,
   parameter int BIN_W = 7,
   parameter logic [IDX_W-1:0] CONTEXT_BIAS = 6'h00
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Coefficient stream from the transform stage
   input wire logic COEF_VALID_I,
   output logic COEF_READY_O,
   input wire logic signed [COEF_W-1:0] COEF_I,
   input wire logic COEF_BAND_LAST_I,
   input wire logic FULLBAND_I,
   // External context and resized code tables
   output logic [SYM_W-1:0] LUT_SYM_O,
   output logic [SYM_W-1:0] LUT_CTX_O,
   input wire logic [CODE_W-1:0] CTX_CODE_I,
   input wire logic [LEN_W-1:0] CTX_LEN_I,
   input wire logic [CODE_W-1:0] RSZ_CODE_I,
   input wire logic [LEN_W-1:0] RSZ_LEN_I,
   // Field stream to the bitstream writer
   output logic FIELD_VALID_O,
   input wire logic FIELD_READY_I,
   output logic [CODE_W-1:0] FIELD_CODE_O,
   output logic [LEN_W-1:0] FIELD_LEN_O,
   output logic FIELD_LAST_O,
   // Reconstructed norms for bit allocation
   input wire logic [IDX_W-1:0] NORM_ADDR_I,
   output logic [IDX_W-1:0] NORM_IDX_O,
   output logic NORM_VALID_O
);
   localparam int SUM_W = 2 * COEF_W + BIN_W;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Log2 in half steps: twice the leading one position, plus one past sqrt2.
   function automatic logic [9:0] log2_half(input logic [SUM_W-1:0] x);
      int p;
      logic [SUM_W-1:0] nx;
      p = 0;
      for (int i = 0; i < SUM_W; i++) begin
         if (x[i]) begin
            p = i;
         end
      end
      nx = x << (SUM_W - 1 - p);
      return 10'(2 * p) + ((nx[SUM_W-2 -: 8] >= LOG_FRAC_THR) ? 10'h001 : 10'h000);
   endfunction

   // Normal Huffman table, returned as {len, code}.
   function automatic logic [LEN_W+6:0] norm_huff(input logic [SYM_W-1:0] s);
      logic [2:0] l;
      logic [6:0] c;
      case (s)
         5'h00: begin l = 3'h7; c = 7'b0011010; end
         5'h01: begin l = 3'h7; c = 7'b0111010; end
         5'h02: begin l = 3'h7; c = 7'b1011010; end
         5'h03: begin l = 3'h7; c = 7'b1111010; end
         5'h04: begin l = 3'h7; c = 7'b0011011; end
         5'h05: begin l = 3'h7; c = 7'b0111011; end
         5'h06: begin l = 3'h7; c = 7'b1011011; end
         5'h07: begin l = 3'h7; c = 7'b1111011; end
         5'h08: begin l = 3'h6; c = 7'b0001100; end
         5'h09: begin l = 3'h6; c = 7'b0011100; end
         5'h0a: begin l = 3'h6; c = 7'b0101100; end
         5'h0b: begin l = 3'h6; c = 7'b0111100; end
         5'h0c: begin l = 3'h4; c = 7'b0000010; end
         5'h0d: begin l = 3'h4; c = 7'b0000110; end
         5'h0e: begin l = 3'h3; c = 7'b0000100; end
         5'h0f: begin l = 3'h3; c = 7'b0000110; end
         5'h10: begin l = 3'h3; c = 7'b0000000; end
         5'h11: begin l = 3'h3; c = 7'b0000010; end
         5'h12: begin l = 3'h4; c = 7'b0001010; end
         5'h13: begin l = 3'h4; c = 7'b0001110; end
         5'h14: begin l = 3'h6; c = 7'b0001110; end
         5'h15: begin l = 3'h6; c = 7'b0011110; end
         5'h16: begin l = 3'h6; c = 7'b0101110; end
         5'h17: begin l = 3'h6; c = 7'b0111110; end
         5'h18: begin l = 3'h7; c = 7'b0011110; end
         5'h19: begin l = 3'h7; c = 7'b0111110; end
         5'h1a: begin l = 3'h7; c = 7'b1011110; end
         5'h1b: begin l = 3'h7; c = 7'b1111110; end
         5'h1c: begin l = 3'h7; c = 7'b0011111; end
         5'h1d: begin l = 3'h7; c = 7'b0111111; end
         5'h1e: begin l = 3'h7; c = 7'b1011111; end
         default: begin l = 3'h7; c = 7'b1111111; end
      endcase
      return {LEN_W'(l), c};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State

   state_type state;
   logic [IDX_W-1:0] idx [0:NBANDS_MAX-1];
   logic [SUM_W-1:0] sum;
   logic [BIN_W-1:0] bin_cnt;
   logic [IDX_W-1:0] band_cnt;
   logic [IDX_W-1:0] nbands;
   logic [IDX_W-1:0] pos;
   logic [COST_W-1:0] cost [0:3];
   mode_type sel;
   logic norm_valid;

   logic [IDX_W-1:0] lo;
   logic [IDX_W-1:0] hi;
   logic [SYM_W-1:0] sym;
   logic [SYM_W-1:0] prev_sym;
   logic [LEN_W+6:0] nh;
   logic [IDX_W-1:0] new_idx;
   logic [2*COEF_W-1:0] sq;
   field_type fin;
   logic fin_valid;
   logic fin_ready;
   field_type fout;
   logic last_pos;

   assign lo = idx[pos];
   assign hi = idx[pos+1'b1];
   assign sym = SYM_W'(hi - lo + SYM_OFFSET); // RQ6 RQ9
   assign prev_sym = SYM_W'(lo - idx[pos-1'b1] + SYM_OFFSET);
   assign nh = norm_huff(sym); // RQ14
   assign last_pos = (pos == nbands - 6'h02);
   assign sq = (2*COEF_W)'(COEF_I * COEF_I);
   assign COEF_READY_O = (state == S_ACC);
   assign LUT_SYM_O = sym;
   assign LUT_CTX_O = (pos == '0) ? SYM_W'(idx[0] - CONTEXT_BIAS) : prev_sym; // RQ12
   assign NORM_VALID_O = norm_valid;

   ////////////////////////////////////////////////////////////////////////////////
   // Norm index from band energy

   // Mean square is sum over length, so 2*log2(rms) = log2(sum) - log2(len).
   always_comb begin
      int d;
      int r;
      d = int'(log2_half(sum)) - int'(log2_half(SUM_W'(bin_cnt))); // RQ1
      r = IDX_TOP - ((d + 1) >>> 1); // RQ2 RQ3
      if (sum == '0 || r > int'(IDX_MAX)) begin
         r = int'(IDX_MAX);
      end else if (r < 0) begin
         r = 0;
      end
      if (band_cnt == '0 && r > int'(IDX_MAX_LOW)) begin
         r = int'(IDX_MAX_LOW); // RQ4
      end
      new_idx = IDX_W'(r); // RQ4
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state <= S_ACC;
         sum <= '0;
         bin_cnt <= '0;
         band_cnt <= '0;
         nbands <= IDX_W'(NBANDS_WB);
         pos <= '0;
         norm_valid <= 1'b0;
      end else begin
         case (state)
            S_ACC: begin
               if (band_cnt == '0 && bin_cnt == '0) begin
                  nbands <= FULLBAND_I ? IDX_W'(NBANDS_FB) : IDX_W'(NBANDS_WB); // RQ16
               end
               if (COEF_VALID_I) begin
                  sum <= sum + SUM_W'(sq); // RQ1
                  bin_cnt <= bin_cnt + 1'b1;
                  if (COEF_BAND_LAST_I) begin
                     state <= S_LOG;
                  end
               end
            end
            S_LOG: begin
               sum <= '0;
               bin_cnt <= '0;
               if (band_cnt == '0) begin
                  norm_valid <= 1'b0;
               end
               if (band_cnt == nbands - 1'b1) begin
                  band_cnt <= '0;
                  pos <= nbands - 6'h02;
                  state <= S_DOWN;
               end else begin
                  band_cnt <= band_cnt + 1'b1;
                  state <= S_ACC;
               end
            end
            S_DOWN: begin
               if (pos == '0) begin
                  state <= S_UP;
               end else begin
                  pos <= pos - 1'b1;
               end
            end
            S_UP: begin
               if (last_pos) begin
                  pos <= '0;
                  state <= S_COST;
               end else begin
                  pos <= pos + 1'b1;
               end
            end
            S_COST: begin
               if (last_pos) begin
                  pos <= '0;
                  state <= S_SEL;
               end else begin
                  pos <= pos + 1'b1;
               end
            end
            S_SEL: begin
               state <= S_EMIT_MODE;
            end
            S_EMIT_MODE: begin
               if (fin_ready) begin
                  state <= S_EMIT_FIRST; // RQ17
               end
            end
            S_EMIT_FIRST: begin
               if (fin_ready) begin
                  state <= S_EMIT_SYM; // RQ17
               end
            end
            S_EMIT_SYM: begin
               if (fin_ready) begin
                  if (last_pos) begin
                     pos <= '0;
                     norm_valid <= 1'b1; // RQ18
                     state <= S_ACC;
                  end else begin
                     pos <= pos + 1'b1;
                  end
               end
            end
            default: begin
               state <= S_ACC;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Index array: store, then downward and upward constraint passes

   always_ff @(posedge CLK_I) begin
      if (state == S_LOG) begin
         idx[band_cnt] <= new_idx;
      end else if (state == S_DOWN && lo > hi + DIFF_NEG_LIMIT) begin
         idx[pos] <= hi; // RQ7
      end else if (state == S_UP && hi > lo + DIFF_POS_LIMIT) begin
         idx[pos+1'b1] <= lo + DIFF_POS_LIMIT; // RQ8
      end
   end

   // The array is only stable between frames; readers should check NORM_VALID_O.
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         NORM_IDX_O <= '0;
      end else begin
         NORM_IDX_O <= idx[NORM_ADDR_I]; // RQ18
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Scheme costing and selection

   always_ff @(posedge CLK_I) begin
      if (RST_I || state == S_DOWN) begin
         for (int m = 0; m < 4; m++) begin
            cost[m] <= '0;
         end
      end else if (state == S_COST) begin
         cost[MODE_CTX] <= cost[MODE_CTX] + COST_W'(CTX_LEN_I); // RQ10
         cost[MODE_RSZ] <= cost[MODE_RSZ] + COST_W'(RSZ_LEN_I); // RQ15
         cost[MODE_NORM] <= cost[MODE_NORM] + COST_W'(nh[LEN_W+6:7]);
         cost[MODE_PACK] <= cost[MODE_PACK] + COST_W'(FIXED_LEN);
      end
   end

   // Ties go to the lower scheme number.
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         sel <= MODE_PACK;
      end else if (state == S_SEL) begin
         if (cost[0] <= cost[1] && cost[0] <= cost[2] && cost[0] <= cost[3]) begin
            sel <= MODE_CTX; // RQ10
         end else if (cost[1] <= cost[2] && cost[1] <= cost[3]) begin
            sel <= MODE_RSZ;
         end else if (cost[2] <= cost[3]) begin
            sel <= MODE_NORM;
         end else begin
            sel <= MODE_PACK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Field emission into the output FIFO

   always_comb begin
      fin = '0;
      fin_valid = 1'b0;
      case (state)
         S_EMIT_MODE: begin
            fin_valid = 1'b1;
            fin.code = CODE_W'(sel); // RQ11
            fin.len = SEL_LEN;
         end
         S_EMIT_FIRST: begin
            fin_valid = 1'b1;
            fin.code = CODE_W'(idx[0]); // RQ5
            fin.len = FIXED_LEN;
         end
         S_EMIT_SYM: begin
            fin_valid = 1'b1;
            fin.last = last_pos;
            case (sel)
               MODE_CTX: begin
                  fin.code = CTX_CODE_I;
                  fin.len = CTX_LEN_I;
               end
               MODE_RSZ: begin
                  fin.code = RSZ_CODE_I; // RQ15
                  fin.len = RSZ_LEN_I;
               end
               MODE_NORM: begin
                  fin.code = CODE_W'(nh[6:0]); // RQ14
                  fin.len = nh[LEN_W+6:7];
               end
               default: begin
                  fin.code = CODE_W'(sym); // RQ13
                  fin.len = FIXED_LEN;
               end
            endcase
         end
         default: begin
            fin_valid = 1'b0;
         end
      endcase
   end

   field_fifo #(
      .WIDTH(FIELD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .in_valid_i(fin_valid),
      .in_ready_o(fin_ready),
      .in_data_i(fin),
      .out_valid_o(FIELD_VALID_O),
      .out_ready_i(FIELD_READY_I),
      .out_data_o(fout)
   );

   assign FIELD_CODE_O = fout.code;
   assign FIELD_LEN_O = fout.len;
   assign FIELD_LAST_O = fout.last;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   a_low_band_sat: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ4
      (state == S_LOG && band_cnt == '0) |=> idx[0] <= IDX_MAX_LOW)
      else $error("lowest band index above 31");
   a_band_sat: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ4
      (state == S_LOG) |=> idx[$past(band_cnt)] <= IDX_MAX)
      else $error("band index above 39");
   a_down_copy: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ7
      (state == S_DOWN && lo > hi + DIFF_NEG_LIMIT) |=> idx[$past(pos)] == $past(hi))
      else $error("downward pass did not copy upper index");
   a_up_clamp: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ8
      (state == S_UP && hi > lo + DIFF_POS_LIMIT) |=> idx[$past(pos) + 1'b1] == $past(lo) + 6'h10)
      else $error("upward pass did not clamp to 16");
   a_diff_range: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ9
      (state == S_COST) |-> (hi + DIFF_NEG_LIMIT >= lo) && (hi <= lo + DIFF_POS_LIMIT))
      else $error("constrained difference out of range");
   a_sel_cheapest: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ10
      (state == S_EMIT_MODE) |-> cost[sel] <= cost[0] && cost[sel] <= cost[1]
         && cost[sel] <= cost[2] && cost[sel] <= cost[3])
      else $error("selected scheme is not the cheapest");
   a_sel_field: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ11
      (state == S_EMIT_MODE && fin_ready) |-> fin.len == 5'h02 && fin.code == CODE_W'(sel)
         ##1 state == S_EMIT_FIRST)
      else $error("scheme field wrong or out of order");
   a_first_field: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ5
      (state == S_EMIT_FIRST) |-> fin_valid && fin.len == 5'h05 && fin.code == CODE_W'(idx[0]))
      else $error("lowest band field wrong");
   a_pack_field: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ13
      (state == S_EMIT_SYM && sel == MODE_PACK) |-> fin.len == 5'h05 && fin.code == CODE_W'(sym))
      else $error("packed symbol field wrong");
   a_norm_centre: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ14
      (state == S_EMIT_SYM && sel == MODE_NORM && sym == 5'h10) |-> fin.len == 5'h03
         && fin.code == '0)
      else $error("symbol 16 not coded as 000");
   a_ctx_first: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ12
      (state == S_COST && pos == '0) |-> LUT_CTX_O == SYM_W'(idx[0] - CONTEXT_BIAS))
      else $error("first context not biased lowest index");
   a_ctx_chain: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ12
      (state == S_COST && pos != '0) |-> LUT_CTX_O == $past(LUT_SYM_O))
      else $error("later context is not the previous symbol");
endmodule

// *** rtl/field_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module field_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// *** shared/norm_code_pkg.sv ***
// Constants, field layouts and state codes shared by the norm quantizer and its bench.
package norm_code_pkg;

   // Band counts per signal bandwidth.
   localparam int NBANDS_WB = 26;
   localparam int NBANDS_FB = 44;
   localparam int NBANDS_MAX = 44;

   // Norm index scale.
   localparam int IDX_W = 6;
   localparam int SYM_W = 5;
   localparam int IDX_TOP = 34;
   localparam logic [IDX_W-1:0] IDX_MAX_LOW = 6'h1f;
   localparam logic [IDX_W-1:0] IDX_MAX = 6'h27;
   localparam logic [IDX_W-1:0] DIFF_NEG_LIMIT = 6'h0f;
   localparam logic [IDX_W-1:0] DIFF_POS_LIMIT = 6'h10;
   localparam logic [IDX_W-1:0] SYM_OFFSET = 6'h0f;

   // Fraction of the normalised mantissa at which log2 passes a half step (sqrt2 - 1).
   localparam logic [7:0] LOG_FRAC_THR = 8'h6a;

   // Field sizes in the output stream.
   localparam int CODE_W = 16;
   localparam int LEN_W = 5;
   localparam int COST_W = 12;
   localparam logic [LEN_W-1:0] SEL_LEN = 5'h02;
   localparam logic [LEN_W-1:0] FIXED_LEN = 5'h05;

   // Output FIFO depth.
   localparam int FIFO_DEPTH = 32;

   typedef enum logic [1:0] {
      MODE_CTX = 2'b00,
      MODE_RSZ = 2'b01,
      MODE_NORM = 2'b10,
      MODE_PACK = 2'b11
   } mode_type;

   typedef enum logic [3:0] {
      S_ACC = 4'b0000,
      S_LOG = 4'b0001,
      S_DOWN = 4'b0010,
      S_UP = 4'b0011,
      S_COST = 4'b0100,
      S_SEL = 4'b0101,
      S_EMIT_MODE = 4'b0110,
      S_EMIT_FIRST = 4'b0111,
      S_EMIT_SYM = 4'b1000
   } state_type;

   // One bitstream field: code right aligned, sent MSB first over len bits.
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic [LEN_W-1:0] len;
      logic last;
   } field_type;

   localparam int FIELD_W = CODE_W + LEN_W + 1;

endpackage
